// ==== rtl/ddc_regs.vh ====
// Register map, field positions, coefficients and sizes of the downconverter
`ifndef DDC_REGS_VH
`define DDC_REGS_VH

`define DDC_AW 13
`define DDC_A_ALIGN 13'h100
`define DDC_A_FIR 13'h102
`define DDC_A_HB 13'h103
`define DDC_A_TUNE 13'h11D
`define DDC_A_FREQ0 13'h11E
`define DDC_A_FREQ1 13'h11F
`define DDC_A_FREQ2 13'h120
`define DDC_A_FREQ3 13'h121
`define DDC_A_PH_LO 13'h122
`define DDC_A_PH_HI 13'h123
`define DDC_REG_RST 8'h00

// tuner_control
`define DDC_B_NCO_EN 0
`define DDC_B_AMP_DITH 1
// align_strobe_control
`define DDC_B_NCO_SYNC_EN 3
`define DDC_B_NCO_SYNC_FIRST 4
`define DDC_B_HB_SYNC_EN 5
`define DDC_B_HB_SYNC_FIRST 6
// halfband_control
`define DDC_B_HP 1
`define DDC_B_REV 2
`define DDC_B_DPH 3
// fir_control
`define DDC_B_FIR_EN 0
`define DDC_B_XLAT_EN 1

// Half-band coefficient magnitudes, signs applied in the sum
`define DDC_C0 40'sh000000034C
`define DDC_C2 40'sh000000182D
`define DDC_C4 40'sh00000061F8
`define DDC_C6 40'sh0000013542
`define DDC_C8 40'sh000004E830
`define DDC_C9 40'sh000007FFFF

`define DDC_LFSR_SEED 16'hACE1
`define DDC_FIFO_W 64
`define DDC_FIFO_D 16
`define DDC_FIFO_AW 4

`endif

// ==== rtl/ddc_fifo.v ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module ddc_fifo #(
  parameter W = 64,
  parameter D = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge mclk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule

// ==== rtl/ddc_downconverter.v ====
// Dual-channel tuning oscillator, half-band decimator and fs/8 translator
// Operation
// RULE1 - Tuning oscillator bypassed when control bit 0 clear, used when set.
// RULE2 - Oscillator turns real samples into frequency-shifted I and Q.
// RULE3 - One shared oscillator drives both channels identically.
// RULE4 - Four byte registers form the 32-bit frequency word.
// RULE5 - Frequency word is twos complement spanning minus to plus half clock.
// RULE6 - Word equals 2^32 times frequency over sample clock.
// RULE7 - Strobe control bits 3/4 pick every strobe or first after write.
// RULE8 - Accepted strobe restarts the accumulator at the phase offset.
// RULE9 - A 16-bit unsigned phase offset adds to the accumulator.
// RULE10 - Offset zero is no shift, full scale is just under one turn.
// RULE11 - Control bit 1 enables amplitude dither in the sine/cosine lookup.
// RULE12 - Phase dither reduces spurs from phase quantisation.
// RULE13 - Half-band stage emits one sample per two inputs.
// RULE14 - Symmetric 19-tap polyphase filter, odd taps zero except centre.
// RULE15 - Coefficients 844, -6189, 25080, -79170, 321584, centre 524287.
// RULE16 - Half-band stays in the path with no control to remove it.
// RULE17 - Half-band control bit 1 selects high-pass, clear selects low-pass.
// RULE18 - Half-band control bit 2 enables spectral reversal.
// RULE19 - Half-band control bit 3 picks first or second sample phase.
// RULE20 - Enabled translator shifts complex output to fs/8 as real data.
// RULE21 - Optional fixed FIR sharpens roll-off after the half-band; its taps are not built here, so enabling it passes data unchanged.
// RULE22 - FIR bypassed when its enable bit is zero; needs half-band.
// RULE23 - Strobe bits 5/6 resync the half-band to its decimation phase.
// RULE24 - Accumulator advances by the word each sample, wrapping mod 2^32.
`timescale 1ns/100ps
`include "ddc_regs.vh"
module ddc_downconverter (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Register port from the serial control core
  input wire [12:0] reg_addr,
  input wire reg_we,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // ADC samples, twos complement
  input wire adc_valid,
  output wire adc_ready,
  input wire [13:0] adc_a,
  input wire [13:0] adc_b,
  // External alignment strobe pin
  input wire sync_pin,
  // Output stream: {b_q, b_i, a_q, a_i}
  output wire out_valid,
  input wire out_ready,
  output wire [63:0] out_data
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] align_r;
  reg [7:0] fir_r;
  reg [7:0] hb_r;
  reg [7:0] tune_r;
  reg [31:0] freq_r;
  reg [15:0] phoff_r;
  reg nco_arm_r;
  reg hb_arm_r;

  always @(posedge mclk) begin
    if (rst) begin
      align_r <= `DDC_REG_RST;
      fir_r <= `DDC_REG_RST;
      hb_r <= `DDC_REG_RST;
      tune_r <= `DDC_REG_RST;
      freq_r <= {4{`DDC_REG_RST}};
      phoff_r <= {2{`DDC_REG_RST}};
    end else if (reg_we) begin
      case (reg_addr)
        `DDC_A_ALIGN: align_r <= reg_wdata;
        `DDC_A_FIR: fir_r <= reg_wdata; // see RULE22
        `DDC_A_HB: hb_r <= reg_wdata;
        `DDC_A_TUNE: tune_r <= reg_wdata;
        `DDC_A_FREQ0: freq_r[7:0] <= reg_wdata; // see RULE4
        `DDC_A_FREQ1: freq_r[15:8] <= reg_wdata; // see RULE4
        `DDC_A_FREQ2: freq_r[23:16] <= reg_wdata; // see RULE4
        `DDC_A_FREQ3: freq_r[31:24] <= reg_wdata; // see RULE4
        `DDC_A_PH_LO: phoff_r[7:0] <= reg_wdata; // see RULE9
        `DDC_A_PH_HI: phoff_r[15:8] <= reg_wdata; // see RULE9
        default: ;
      endcase
    end
  end

  always @* begin
    case (reg_addr)
      `DDC_A_ALIGN: reg_rdata = align_r;
      `DDC_A_FIR: reg_rdata = fir_r;
      `DDC_A_HB: reg_rdata = hb_r;
      `DDC_A_TUNE: reg_rdata = tune_r;
      `DDC_A_FREQ0: reg_rdata = freq_r[7:0];
      `DDC_A_FREQ1: reg_rdata = freq_r[15:8];
      `DDC_A_FREQ2: reg_rdata = freq_r[23:16];
      `DDC_A_FREQ3: reg_rdata = freq_r[31:24];
      `DDC_A_PH_LO: reg_rdata = phoff_r[7:0];
      `DDC_A_PH_HI: reg_rdata = phoff_r[15:8];
      default: reg_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Alignment strobe: synchroniser, edge detect, accept logic
  reg sync_m_r;
  reg sync_s_r;
  reg sync_d_r;
  wire sync_rise;
  wire nco_sync;
  wire hb_sync;
  wire align_wr;

  assign sync_rise = sync_s_r & ~sync_d_r;
  assign align_wr = reg_we & (reg_addr == `DDC_A_ALIGN);
  // First-only mode needs the arm flag that a write to the alignment register set
  assign nco_sync = sync_rise & align_r[`DDC_B_NCO_SYNC_EN] &
                    (~align_r[`DDC_B_NCO_SYNC_FIRST] | nco_arm_r); // see RULE7
  assign hb_sync = sync_rise & align_r[`DDC_B_HB_SYNC_EN] &
                   (~align_r[`DDC_B_HB_SYNC_FIRST] | hb_arm_r); // see RULE23

  always @(posedge mclk) begin
    if (rst) begin
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      sync_d_r <= 1'b0;
      nco_arm_r <= 1'b0;
      hb_arm_r <= 1'b0;
    end else begin
      sync_m_r <= sync_pin;
      sync_s_r <= sync_m_r;
      sync_d_r <= sync_s_r;
      // A write arms again even if a strobe is taken in the same cycle
      if (align_wr) begin
        nco_arm_r <= 1'b1;
        hb_arm_r <= 1'b1;
      end else begin
        if (nco_sync) begin
          nco_arm_r <= 1'b0;
        end
        if (hb_sync) begin
          hb_arm_r <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tuning oscillator
  reg [31:0] acc_r;
  reg [15:0] lfsr_r;
  reg calc_r;
  reg push_r;
  wire take;
  wire [15:0] phase;
  wire [5:0] pidx;
  wire signed [11:0] sin_v;
  wire signed [11:0] cos_v;
  wire signed [11:0] dith;

  assign adc_ready = ~calc_r & ~push_r;
  assign take = adc_valid & adc_ready;

  // Dither on the bits below the table index breaks up phase truncation
  assign phase = acc_r[31:16] + phoff_r + {6'h00, lfsr_r[9:0]}; // see RULE9, RULE10, RULE12
  assign pidx = phase[15:10];
  assign dith = {11'h000, lfsr_r[15] & tune_r[`DDC_B_AMP_DITH]}; // see RULE11
  assign sin_v = qsin(pidx) + dith;
  assign cos_v = qsin(pidx + 6'h10) + dith;

  // Quarter-wave table of 2047*sin, 64 points per turn
  function signed [11:0] qsin;
    input [5:0] p;
    reg [3:0] k;
    reg [11:0] t;
    begin
      k = p[4] ? ~p[3:0] : p[3:0];
      case (k)
        4'h0: t = 12'h064;
        4'h1: t = 12'h12C;
        4'h2: t = 12'h1F1;
        4'h3: t = 12'h2B2;
        4'h4: t = 12'h36B;
        4'h5: t = 12'h41C;
        4'h6: t = 12'h4C3;
        4'h7: t = 12'h55F;
        4'h8: t = 12'h5ED;
        4'h9: t = 12'h66C;
        4'hA: t = 12'h6DC;
        4'hB: t = 12'h73A;
        4'hC: t = 12'h787;
        4'hD: t = 12'h7C2;
        4'hE: t = 12'h7E9;
        default: t = 12'h7FD;
      endcase
      qsin = p[5] ? -t : t;
    end
  endfunction

  always @(posedge mclk) begin
    if (rst) begin
      acc_r <= 32'h00000000;
      lfsr_r <= `DDC_LFSR_SEED;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      if (nco_sync) begin
        acc_r <= 32'h00000000; // see RULE8
      end else if (take) begin
        acc_r <= acc_r + freq_r; // see RULE24, RULE5, RULE6
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mixers: lanes 0/1 are channel A I/Q, lanes 2/3 channel B I/Q
  wire signed [25:0] a_c;
  wire signed [25:0] a_s;
  wire signed [25:0] b_c;
  wire signed [25:0] b_s;
  wire [63:0] mix_bus;
  wire nco_on;

  assign nco_on = tune_r[`DDC_B_NCO_EN];
  assign a_c = $signed(adc_a) * cos_v; // see RULE2, RULE3
  assign a_s = $signed(adc_a) * sin_v;
  assign b_c = $signed(adc_b) * cos_v; // see RULE3
  assign b_s = $signed(adc_b) * sin_v;
  // Bypass keeps the same scale as the mixer so gain does not jump
  assign mix_bus[15:0] = nco_on ? a_c[25:10] : {adc_a[13], adc_a, 1'b0}; // see RULE1
  assign mix_bus[31:16] = nco_on ? -a_s[25:10] : 16'h0000;
  assign mix_bus[47:32] = nco_on ? b_c[25:10] : {adc_b[13], adc_b, 1'b0};
  assign mix_bus[63:48] = nco_on ? -b_s[25:10] : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Half-band decimator, always in the path
  reg ph_r;
  reg rev_r;
  reg [1:0] quad_r;
  wire ph_nxt;
  wire [63:0] hb_bus;
  wire hp;

  assign hp = hb_r[`DDC_B_HP];
  assign ph_nxt = hb_sync ? hb_r[`DDC_B_DPH] : ph_r; // see RULE19, RULE23

  always @(posedge mclk) begin
    if (rst) begin
      ph_r <= 1'b0;
      calc_r <= 1'b0;
    end else begin
      calc_r <= take & ~ph_nxt; // see RULE13, RULE16
      ph_r <= take ? ~ph_nxt : ph_nxt;
    end
  end

  genvar ln;
  genvar tp;
  generate
    for (ln = 0; ln < 4; ln = ln + 1) begin : g_lane
      reg [15:0] sr [0:18];
      wire signed [39:0] ex [0:18];
      wire signed [39:0] pairs;
      wire signed [39:0] acc;
      wire [15:0] y;
      integer j;
      for (tp = 0; tp < 19; tp = tp + 1) begin : g_tap
        assign ex[tp] = {{24{sr[tp][15]}}, sr[tp]};
      end
      // Polyphase: only even taps and the centre carry weight
      assign pairs = `DDC_C0 * (ex[0] + ex[18]) - `DDC_C2 * (ex[2] + ex[16])
                   + `DDC_C4 * (ex[4] + ex[14]) - `DDC_C6 * (ex[6] + ex[12])
                   + `DDC_C8 * (ex[8] + ex[10]); // see RULE14, RULE15
      // High-pass flips every tap at odd distance from the centre
      assign acc = hp ? `DDC_C9 * ex[9] - pairs : `DDC_C9 * ex[9] + pairs; // see RULE17
      // Reversal negates every other decimated output
      assign y = (hb_r[`DDC_B_REV] & rev_r) ? -acc[35:20] : acc[35:20]; // see RULE18
      assign hb_bus[16*ln+15:16*ln] = y;
      always @(posedge mclk) begin
        if (rst) begin
          for (j = 0; j < 19; j = j + 1) begin
            sr[j] <= 16'h0000;
          end
        end else if (take) begin
          sr[0] <= mix_bus[16*ln+15:16*ln];
          for (j = 1; j < 19; j = j + 1) begin
            sr[j] <= sr[j-1];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Optional fixed FIR sits here; its taps are not built, so enabling it
  // passes data unchanged and only the enable bit is held for software.
  // see RULE21
  // fs/8 translator: at the half rate, fs/8 is a quarter turn per output
  reg [63:0] push_d_r;
  wire xlat;
  wire push_ok;

  assign xlat = fir_r[`DDC_B_XLAT_EN];

  function [15:0] rot;
    input [1:0] q;
    input [15:0] i;
    input [15:0] qd;
    begin
      case (q)
        2'h0: rot = i;
        2'h1: rot = -qd;
        2'h2: rot = -i;
        default: rot = qd;
      endcase
    end
  endfunction

  always @(posedge mclk) begin
    if (rst) begin
      rev_r <= 1'b0;
      quad_r <= 2'h0;
      push_r <= 1'b0;
      push_d_r <= 64'h0000000000000000;
    end else begin
      if (hb_sync) begin
        rev_r <= 1'b0;
        quad_r <= 2'h0;
      end else if (calc_r) begin
        rev_r <= ~rev_r;
        quad_r <= quad_r + 2'h1;
      end
      if (calc_r) begin
        push_r <= 1'b1;
        if (xlat) begin
          push_d_r <= {16'h0000, rot(quad_r, hb_bus[47:32], hb_bus[63:48]),
                       16'h0000, rot(quad_r, hb_bus[15:0], hb_bus[31:16])}; // see RULE20
        end else begin
          push_d_r <= hb_bus;
        end
      end else if (push_ok) begin
        push_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output FIFO; when full the push stage holds and input stalls
  wire fifo_in_ready;

  assign push_ok = push_r & fifo_in_ready;

  ddc_fifo #(
    .W(`DDC_FIFO_W),
    .D(`DDC_FIFO_D),
    .AW(`DDC_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(push_r),
    .in_ready(fifo_in_ready),
    .in_data(push_d_r),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

endmodule

// ==== testbench/ddc_chk_monitor.sv ====
// Port protocol checker for the downconverter
`timescale 1ns/100ps
`include "ddc_regs.vh"
module ddc_chk_monitor (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Register port
  input wire [12:0] reg_addr,
  input wire reg_we,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Streams
  input wire adc_valid,
  input wire adc_ready,
  input wire out_valid,
  input wire out_ready,
  input wire [63:0] out_data
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire map = reg_addr == `DDC_A_ALIGN || reg_addr == `DDC_A_HB ||
    (reg_addr >= `DDC_A_TUNE && reg_addr <= `DDC_A_PH_HI);
  wire take = adc_valid && adc_ready;
  ////////////////////////////////////////
  property p_rst;
    disable iff (1'b0) rst |=> adc_ready && !out_valid;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_unmap;
    !map && reg_addr != `DDC_A_FIR |-> reg_rdata == `DDC_REG_RST;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_wr_rd;
    reg_we && map |=> reg_addr != $past(reg_addr) || reg_rdata == $past(reg_wdata);
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("readback");
  property p_calc;
    $fell(adc_ready) |=> !adc_ready;
  endproperty
  a_calc: assert property (p_calc) else $error("ready low too short");
  property p_cause;
    $fell(adc_ready) |-> $past(take);
  endproperty
  a_cause: assert property (p_cause) else $error("stall without sample");
  property p_push;
    $fell(adc_ready) && !out_valid |-> ##2 out_valid && adc_ready;
  endproperty
  a_push: assert property (p_push) else $error("push latency");
  property p_pair;
    take ##1 take |=> !adc_ready;
  endproperty
  a_pair: assert property (p_pair) else $error("decimation");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_hold: assert property (p_hold) else $error("output not held");
  property p_drop;
    $fell(out_valid) |-> $past(out_ready);
  endproperty
  a_drop: assert property (p_drop) else $error("output lost");
endmodule
bind ddc_downconverter ddc_chk_monitor chk (.mclk, .rst, .reg_addr, .reg_we, .reg_wdata,
  .reg_rdata, .adc_valid, .adc_ready, .out_valid, .out_ready, .out_data);

// ==== testbench/ddc_adc_model.sv ====
// Sample source standing in for the converter core
`timescale 1ns/100ps
module ddc_adc_model (
  // Clock
  input wire mclk,
  // Bench control
  input wire go,
  input wire [7:0] num,
  input wire [13:0] lvl,
  input wire slow,
  // Sample port
  input wire adc_ready,
  output reg adc_valid,
  output reg [13:0] adc_a,
  output reg [13:0] adc_b
);
  integer left = 0;
  reg took = 0;
  initial begin
    adc_valid = 0;
    adc_a = 14'h3FFF;
    adc_b = 14'h3FFF;
  end
  always @(posedge mclk) begin
    took = adc_valid && adc_ready;
    if (took) left = left - 1;
    if (go) left = num;
    #1;
    // A slow source idles one cycle after each taken sample
    adc_valid = left > 0 && !(slow && took);
    // Idle lines show the complement, never a stale sample
    adc_a = adc_valid ? lvl : ~lvl;
    adc_b = adc_valid ? lvl : ~lvl;
  end
endmodule

// ==== testbench/ddc_nco_halfband_decimator_bench.sv ====
// Self-checking bench for the tuning oscillator and half-band path
`timescale 1ns/100ps
`include "ddc_regs.vh"
module ddc_nco_halfband_decimator_bench;
  reg mclk = 0;
  reg rst = 1;
  reg [12:0] reg_addr = 13'h000;
  reg reg_we = 0;
  reg [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire adc_valid;
  wire adc_ready;
  wire [13:0] adc_a;
  wire [13:0] adc_b;
  reg sync_pin = 0;
  wire out_valid;
  reg out_ready = 1;
  wire [63:0] out_data;
  reg go = 0;
  reg [7:0] num = 8'h00;
  reg [13:0] lvl = 14'h03E8;
  reg slow = 0;
  integer err_total = 0;
  integer comparisons = 0;
  integer k;
  logic [63:0] q [$];
  ddc_downconverter dut (.mclk, .rst, .reg_addr, .reg_we, .reg_wdata, .reg_rdata,
    .adc_valid, .adc_ready, .adc_a, .adc_b, .sync_pin, .out_valid, .out_ready, .out_data);
  ddc_adc_model src (.mclk, .go, .num, .lvl, .slow, .adc_ready, .adc_valid, .adc_a, .adc_b);
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (out_valid && out_ready) q.push_back(out_data);
  ////////////////////////////////////////
  task give_verdict;
    begin
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task bad(input logic [31:0] got, input logic [31:0] exp);
    begin
      err_total = err_total + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task check_eq(input logic [31:0] got, input logic [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) bad(got, exp);
    end
  endtask
  task check_near(input logic signed [15:0] got, input integer exp, input integer tol);
    begin
      comparisons = comparisons + 1;
      if ($isunknown(got) || got - exp > tol || exp - got > tol) bad(got, exp);
    end
  endtask
  task wr(input [12:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_we = 1;
      @(posedge mclk);
      #1;
      reg_we = 0;
    end
  endtask
  task rd(input [12:0] a, input [7:0] e);
    begin
      @(posedge mclk);
      #1;
      reg_addr = a;
      #2;
      check_eq(reg_rdata, e);
    end
  endtask
  task start(input [7:0] n);
    begin
      @(posedge mclk);
      #1;
      num = n;
      go = 1;
      @(posedge mclk);
      #1;
      go = 0;
    end
  endtask
  ////////////////////////////////////////
  task regs;
    reg [12:0] a;
    integer i;
    begin
      for (i = 0; i < 10; i = i + 1) begin
        a = i == 0 ? `DDC_A_ALIGN : i == 1 ? `DDC_A_HB : i == 9 ? `DDC_A_FIR :
          13'(`DDC_A_TUNE + i - 2);
        rd(a, `DDC_REG_RST);
        wr(a, 8'hA5 ^ i[7:0]);
        rd(a, 8'hA5 ^ i[7:0]);
        wr(a, 8'h00);
      end
      wr(13'h101, 8'hFF);
      rd(13'h101, 8'h00);
    end
  endtask
  // Stall the sink until the buffer refuses, then drain and judge the settled tail
  task dc(input [7:0] hb, input [7:0] tn, input [7:0] xl, input [31:0] fr, input [15:0] ph,
    input integer ei, input integer ti, input integer eq, input integer tq,
    input integer es, input integer ts);
    logic signed [15:0] a;
    logic signed [15:0] s;
    begin
      wr(`DDC_A_HB, hb);
      wr(`DDC_A_TUNE, tn);
      wr(`DDC_A_FIR, xl);
      for (k = 0; k < 4; k = k + 1) wr(13'(`DDC_A_FREQ0 + k), fr[8*k +: 8]);
      wr(`DDC_A_PH_LO, ph[7:0]);
      wr(`DDC_A_PH_HI, ph[15:8]);
      // Accumulator keeps running in bypass, so restart it from the strobe
      wr(`DDC_A_ALIGN, 8'h08);
      pulse;
      q.delete();
      out_ready = 0;
      start(8'h28);
      repeat (150) @(posedge mclk);
      check_eq(src.left > 0, 1);
      #1;
      out_ready = 1;
      for (k = 0; k < 300 && q.size() < 20; k = k + 1) @(posedge mclk);
      repeat (10) @(posedge mclk);
      check_eq(q.size(), 20);
      a = q[19][15:0];
      s = q[18][15:0] + q[19][15:0];
      check_near(a < 0 ? -a : a, ei, ti);
      check_near(q[19][31:16], eq, tq);
      check_near(s < 0 ? -s : s, es, ts);
      check_eq(q[19][63:32], q[19][31:0]);
    end
  endtask
  task pulse;
    begin
      @(posedge mclk);
      #1;
      sync_pin = 1;
      repeat (2) @(posedge mclk);
      #1;
      sync_pin = 0;
      repeat (6) @(posedge mclk);
    end
  endtask
  task one(input logic e);
    begin
      start(8'h01);
      @(posedge mclk);
      #2;
      check_eq(adc_ready, e);
      repeat (4) @(posedge mclk);
    end
  endtask
  task sync_case(input [7:0] hb, input [7:0] al, input logic e1, input logic e2);
    begin
      wr(`DDC_A_HB, hb);
      wr(`DDC_A_ALIGN, al);
      pulse;
      one(e1);
      pulse;
      one(e2);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    rst = 0;
    regs;
    dc(8'h00, 8'h00, 8'h00, 32'h12345678, 16'h0000, 2000, 2, 0, 0, 4000, 4);
    dc(8'h02, 8'h00, 8'h00, 32'h00000000, 16'h0000, 0, 1, 0, 0, 0, 2);
    dc(8'h04, 8'h00, 8'h00, 32'h00000000, 16'h0000, 2000, 2, 0, 0, 0, 4);
    slow = 1;
    dc(8'h00, 8'h03, 8'h00, 32'h00000000, 16'h0000, 2000, 250, 0, 250, 4000, 500);
    dc(8'h00, 8'h01, 8'h00, 32'h00000000, 16'h4000, 0, 250, -2000, 250, 0, 500);
    dc(8'h00, 8'h01, 8'h00, 32'h80000000, 16'h0000, 0, 250, 0, 250, 0, 500);
    slow = 0;
    dc(8'h00, 8'h00, 8'h02, 32'h00000000, 16'h0000, 1000, 1000, 0, 0, 2000, 4);
    sync_case(8'h00, 8'h28, 0, 0);
    sync_case(8'h08, 8'h28, 1, 1);
    sync_case(8'h08, 8'h78, 1, 0);
    give_verdict;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    err_total = err_total + 1;
    give_verdict;
  end
endmodule
